/* File: shared/nis_pkg.sv */
// Constants for the nested interrupt state logic
package nis_pkg;
  // -------------------------------------------
  // Sizes
  // -------------------------------------------
  localparam int NIRQ = 33;
  localparam int PW = 3;
  localparam int IW = 6;
  localparam int AW = 8;
  localparam int SW = 2;
  localparam int GW = 2;
  localparam int DW = 32;
  localparam int VW = 64;
  // -------------------------------------------
  // Register byte offsets
  // -------------------------------------------
  localparam logic [7:0] OFF_SETPEND0 = 8'h00;
  localparam logic [7:0] OFF_SETPEND1 = 8'h04;
  localparam logic [7:0] OFF_CLRPEND0 = 8'h08;
  localparam logic [7:0] OFF_CLRPEND1 = 8'h0c;
  localparam logic [7:0] OFF_ACTIVE0 = 8'h10;
  localparam logic [7:0] OFF_ACTIVE1 = 8'h14;
  localparam logic [7:0] OFF_ENABLE0 = 8'h18;
  localparam logic [7:0] OFF_ENABLE1 = 8'h1c;
  localparam logic [7:0] OFF_PULSE0 = 8'h20;
  localparam logic [7:0] OFF_PULSE1 = 8'h24;
  localparam logic [7:0] OFF_SOFTWARE_IRQ_TRIGGER = 8'h28;
  localparam logic [7:0] OFF_PRIGRP = 8'h2c;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  localparam logic [7:0] OFF_MASK = 8'h34;
  localparam logic [7:0] OFF_ARB = 8'h38;
  localparam logic [7:0] OFF_PRI0 = 8'h40;
  localparam logic [7:0] OFF_PRILAST = 8'h60;
  // -------------------------------------------
  // Field positions
  // -------------------------------------------
  localparam int STS_NMI = 0;
  localparam int STS_PEND = 1;
  localparam int ARB_ID = 0;
  localparam int ARB_PRI = 8;
  localparam int ARB_VAL = 31;
  localparam int PRI_LANE = 8;
  localparam int PRI_PER_WORD = 4;
  // -------------------------------------------
  // Reset values
  // -------------------------------------------
  localparam logic [GW-1:0] RST_PRIGRP = 2'h0;
  localparam logic [SW-1:0] RST_MASK = 2'h0;
endpackage : nis_pkg

/* File: rtl/nis_ctrl.sv */
// Nested interrupt state logic with an AHB-Lite register slave
`timescale 1ns/100ps
module nis_ctrl #(
  parameter int N = nis_pkg::NIRQ
) (
  // Clock and reset
  input logic hclk,
  input logic hresetn,
  // AHB-Lite slave
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Request lines
  input logic [N-1:0] irq_line,
  input logic nmi_line,
  // Processor handshake
  input logic core_enter,
  input logic [nis_pkg::IW-1:0] core_enter_id,
  input logic core_exit,
  input logic [nis_pkg::IW-1:0] core_exit_id,
  input logic nmi_ack,
  // Arbitration result, NMI request and interrupt output
  output logic irq_req,
  output logic [nis_pkg::IW-1:0] irq_id,
  output logic [nis_pkg::PW-1:0] irq_grp,
  output logic [nis_pkg::PW-1:0] irq_sub,
  output logic nmi_req,
  output logic irq_out
);
  // -------------------------------------------
  // State
  // -------------------------------------------
  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] prv;
    logic [N-1:0] pend;
    logic [N-1:0] act;
    logic [N-1:0] en;
    logic [N-1:0] pls;
    logic [N-1:0][nis_pkg::PW-1:0] pri;
    logic [nis_pkg::GW-1:0] pg;
    logic n1;
    logic n2;
    logic np;
    logic nmi;
    logic [nis_pkg::SW-1:0] sts;
    logic [nis_pkg::SW-1:0] msk;
    logic dw;
    logic rd;
    logic rdy;
    logic resp;
    logic [nis_pkg::AW-1:0] da;
    logic [nis_pkg::DW-1:0] rdata;
    logic aval;
    logic [nis_pkg::IW-1:0] aid;
    logic [nis_pkg::PW-1:0] agrp;
    logic [nis_pkg::PW-1:0] asub;
    logic irq;
  } nis_st_t;

  localparam nis_st_t RST = '{
    rdy: 1'b1,
    pg: nis_pkg::RST_PRIGRP,
    msk: nis_pkg::RST_MASK,
    default: '0
  };

  nis_st_t r_r;
  nis_st_t r_nxt;

  logic acc;
  logic [N-1:0] rise;
  logic [N-1:0] setv;
  logic [N-1:0] clrv;
  logic [nis_pkg::VW-1:0] s64;
  logic [nis_pkg::VW-1:0] c64;
  logic [nis_pkg::VW-1:0] p64;
  logic [nis_pkg::VW-1:0] a64;
  logic [nis_pkg::VW-1:0] e64;
  logic [nis_pkg::VW-1:0] l64;
  logic [nis_pkg::DW-1:0] rd;
  logic [nis_pkg::SW-1:0] ev;
  logic [nis_pkg::SW-1:0] w1c;
  logic nrise;
  logic found;
  logic [nis_pkg::PW-1:0] bp;
  logic [nis_pkg::IW-1:0] bi;
  logic [nis_pkg::AW-1:0] pk;
  logic pwr;
  int idx;

  // -------------------------------------------
  // Next state
  // -------------------------------------------
  always_comb begin
    r_nxt = r_r;
    s64 = '0;
    c64 = '0;
    rd = '0;
    w1c = '0;
    pwr = 1'b0;
    found = 1'b0;
    bp = '1;
    bi = '0;
    idx = 0;
    // Two flops before any logic sees a pin
    r_nxt.s1 = irq_line;
    r_nxt.s2 = r_r.s1;
    r_nxt.prv = r_r.s2;
    r_nxt.n1 = nmi_line;
    r_nxt.n2 = r_r.n1;
    r_nxt.np = r_r.n2;
    rise = r_r.s2 & ~r_r.prv;
    nrise = r_r.n2 && !r_r.np;
    p64 = nis_pkg::VW'(r_r.pend);
    a64 = nis_pkg::VW'(r_r.act);
    e64 = nis_pkg::VW'(r_r.en);
    l64 = nis_pkg::VW'(r_r.pls);
    pk = (r_r.da - nis_pkg::OFF_PRI0) >> 2;
    // Address phase; reads take one wait state so
    // a write in the prior data phase is seen
    acc = hsel && htrans[1] && hready;
    r_nxt.dw = acc && hwrite;
    r_nxt.rd = acc && !hwrite;
    r_nxt.rdy = !(acc && !hwrite);
    r_nxt.resp = 1'b0;
    if (acc) begin
      r_nxt.da = haddr[nis_pkg::AW-1:0];
    end
    // ---------------------------------------
    // Register read
    // ---------------------------------------
    unique case (r_r.da)
      nis_pkg::OFF_SETPEND0,
      nis_pkg::OFF_CLRPEND0: rd = p64[31:0];
      nis_pkg::OFF_SETPEND1,
      nis_pkg::OFF_CLRPEND1: rd = p64[63:32];
      nis_pkg::OFF_ACTIVE0: rd = a64[31:0];
      nis_pkg::OFF_ACTIVE1: rd = a64[63:32];
      nis_pkg::OFF_ENABLE0: rd = e64[31:0];
      nis_pkg::OFF_ENABLE1: rd = e64[63:32];
      nis_pkg::OFF_PULSE0: rd = l64[31:0];
      nis_pkg::OFF_PULSE1: rd = l64[63:32];
      nis_pkg::OFF_PRIGRP: rd = nis_pkg::DW'(r_r.pg);
      nis_pkg::OFF_STATUS: rd = nis_pkg::DW'(r_r.sts);
      nis_pkg::OFF_MASK: rd = nis_pkg::DW'(r_r.msk);
      nis_pkg::OFF_ARB: begin
        rd[nis_pkg::ARB_ID +: nis_pkg::IW] = r_r.aid;
        rd[nis_pkg::ARB_PRI +: nis_pkg::PW] = {r_r.agrp} << r_r.pg
          | r_r.asub;
        rd[nis_pkg::ARB_VAL] = r_r.aval;
      end
      default: begin
        if (r_r.da >= nis_pkg::OFF_PRI0
            && r_r.da <= nis_pkg::OFF_PRILAST) begin
          for (int j = 0; j < nis_pkg::PRI_PER_WORD; j++) begin
            idx = int'(pk) * nis_pkg::PRI_PER_WORD + j;
            if (idx < N) begin
              rd[j*nis_pkg::PRI_LANE +: nis_pkg::PW] = r_r.pri[idx];
            end
          end
        end
      end
    endcase
    if (r_r.rd) begin
      r_nxt.rdata = rd;
    end
    // ---------------------------------------
    // Register write, data phase
    // ---------------------------------------
    if (r_r.dw) begin
      unique case (r_r.da)
        nis_pkg::OFF_SETPEND0: s64[31:0] = hwdata;
        nis_pkg::OFF_SETPEND1: s64[63:32] = hwdata;
        nis_pkg::OFF_CLRPEND0: c64[31:0] = hwdata;
        nis_pkg::OFF_CLRPEND1: c64[63:32] = hwdata;
        nis_pkg::OFF_ENABLE0: e64[31:0] = hwdata;
        nis_pkg::OFF_ENABLE1: e64[63:32] = hwdata;
        nis_pkg::OFF_PULSE0: l64[31:0] = hwdata;
        nis_pkg::OFF_PULSE1: l64[63:32] = hwdata;
        nis_pkg::OFF_SOFTWARE_IRQ_TRIGGER: begin
          s64[hwdata[nis_pkg::IW-1:0]] = 1'b1;
        end
        nis_pkg::OFF_PRIGRP: begin
          r_nxt.pg = hwdata[nis_pkg::GW-1:0];
        end
        nis_pkg::OFF_STATUS: w1c = hwdata[nis_pkg::SW-1:0];
        nis_pkg::OFF_MASK: r_nxt.msk = hwdata[nis_pkg::SW-1:0];
        default: begin
          pwr = r_r.da >= nis_pkg::OFF_PRI0
            && r_r.da <= nis_pkg::OFF_PRILAST;
        end
      endcase
    end
    r_nxt.en = e64[N-1:0];
    r_nxt.pls = l64[N-1:0];
    setv = s64[N-1:0];
    clrv = c64[N-1:0];
    // ---------------------------------------
    // Per-input state
    // ---------------------------------------
    // Clears first, sets last, so an event in
    // the clearing cycle survives
    for (int i = 0; i < N; i++) begin
      if (pwr && i / nis_pkg::PRI_PER_WORD == int'(pk)) begin
        r_nxt.pri[i] = hwdata[(i % nis_pkg::PRI_PER_WORD)
          * nis_pkg::PRI_LANE +: nis_pkg::PW];
      end
      if (core_exit && int'(core_exit_id) == i) begin
        r_nxt.act[i] = 1'b0;
        if (!r_r.pls[i]) begin
          r_nxt.pend[i] = r_r.s2[i];
        end
      end
      if (core_enter && int'(core_enter_id) == i) begin
        r_nxt.act[i] = 1'b1;
        r_nxt.pend[i] = 1'b0;
      end
      if (clrv[i]) begin
        if (r_r.pls[i]) begin
          r_nxt.pend[i] = 1'b0;
        end else if (!r_r.s2[i]) begin
          r_nxt.pend[i] = 1'b0;
        end
      end
      if (r_r.pls[i] && rise[i]) begin
        r_nxt.pend[i] = 1'b1;
      end
      if (!r_r.pls[i] && r_r.s2[i] && !r_r.act[i]
          && !(core_enter && int'(core_enter_id) == i)) begin
        r_nxt.pend[i] = 1'b1;
      end
      if (setv[i]) begin
        r_nxt.pend[i] = 1'b1;
      end
    end
    // ---------------------------------------
    // Non-maskable input
    // ---------------------------------------
    if (nmi_ack) begin
      r_nxt.nmi = 1'b0;
    end
    if (nrise) begin
      r_nxt.nmi = 1'b1;
    end
    // ---------------------------------------
    // Arbitration
    // ---------------------------------------
    // Walk downward so ties go to the lowest id
    for (int i = N - 1; i >= 0; i--) begin
      if (r_r.pend[i] && r_r.en[i] && !r_r.act[i]
          && (!found || r_r.pri[i] <= bp)) begin
        found = 1'b1;
        bp = r_r.pri[i];
        bi = nis_pkg::IW'(i);
      end
    end
    r_nxt.aval = found;
    r_nxt.aid = bi;
    r_nxt.agrp = bp >> r_r.pg;
    r_nxt.asub = bp & ~({nis_pkg::PW{1'b1}} << r_r.pg);
    // ---------------------------------------
    // Event status and interrupt output
    // ---------------------------------------
    ev = '0;
    ev[nis_pkg::STS_NMI] = nrise;
    ev[nis_pkg::STS_PEND] = |(r_nxt.pend & ~r_r.pend);
    r_nxt.sts = (r_r.sts & ~w1c) | ev;
    r_nxt.irq = |(r_nxt.sts & r_nxt.msk);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_r <= RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // -------------------------------------------
  // Outputs
  // -------------------------------------------
  assign hreadyout = r_r.rdy;
  assign hresp = r_r.resp;
  assign hrdata = r_r.rdata;
  assign irq_req = r_r.aval;
  assign irq_id = r_r.aid;
  assign irq_grp = r_r.agrp;
  assign irq_sub = r_r.asub;
  assign nmi_req = r_r.nmi;
  assign irq_out = r_r.irq;

  // -------------------------------------------
  // Checks
  // -------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  chk_reset_idle: assert property (
    $past(!hresetn) |-> r_r.pend == '0 && r_r.act == '0)
    else $error("state not idle after reset");

  // Per input, so whichever line the bench drives is watched
  for (genvar g = 0; g < N; g++) begin : g_chk
    logic ent;
    logic ext;
    assign ent = core_enter && int'(core_enter_id) == g;
    assign ext = core_exit && int'(core_exit_id) == g;
    chk_pulse_latch: assert property (
      r_r.pls[g] && rise[g] |=> r_r.pend[g] ##1 r_r.pend[g]
        || r_r.act[g] || $past(clrv[g]) || $past(ent))
      else $error("pulse not latched");
    chk_level_pend: assert property (
      !r_r.pls[g] && r_r.s2[g] && !r_r.act[g] && !ent |=> r_r.pend[g])
      else $error("level line did not pend");
    chk_enter_act: assert property (
      ent && !r_r.pls[g] && !setv[g] |=> r_r.act[g] && !r_r.pend[g])
      else $error("entry did not activate");
    chk_level_exit: assert property (
      ext && !ent && !r_r.pls[g] && !setv[g]
        |=> !r_r.act[g] && r_r.pend[g] == $past(r_r.s2[g]))
      else $error("level exit state wrong");
    chk_pulse_exit: assert property (
      ext && !ent && r_r.pls[g] && !r_r.pend[g] && !rise[g] && !setv[g]
        |=> !r_r.act[g] && !r_r.pend[g])
      else $error("pulse exit not inactive");
    chk_pulse_clr: assert property (
      clrv[g] && r_r.pls[g] && !rise[g] && !setv[g] && !ent && !ext
        |=> !r_r.pend[g] && r_r.act[g] == $past(r_r.act[g]))
      else $error("pulse clear wrong");
    chk_software_irq_trigger_pend: assert property (
      setv[g] |=> r_r.pend[g])
      else $error("software set lost");
    chk_zero_wins: assert property (
      r_r.pend[g] && r_r.en[g] && !r_r.act[g] && r_r.pri[g] == '0
        |=> irq_req && irq_grp == '0 && irq_sub == '0
        && int'(irq_id) <= g)
      else $error("level zero did not win");
  end
  chk_nmi_latch: assert property (
    nrise |=> nmi_req ##1 nmi_req || $past(nmi_ack))
    else $error("nmi not latched");

  cov_enter: cover property (core_enter ##[1:4] core_exit);
  cov_nmi: cover property (nrise ##[1:4] nmi_ack);
  cov_read: cover property (r_r.rd ##1 hreadyout);
  cov_act_pend: cover property (|(r_r.act & r_r.pend));
endmodule : nis_ctrl

/* File: tb/nis_periph.sv */
// Peripheral model driving level and pulse request lines
`timescale 1ns/100ps
module nis_periph (
  // Clock and reset
  hclk,
  hresetn,
  // Commands from the bench
  lvl,
  pls,
  // Request lines
  irq_line
);
  input wire logic hclk;
  input wire logic hresetn;
  input wire logic [nis_pkg::NIRQ-1:0] lvl;
  input wire logic [nis_pkg::NIRQ-1:0] pls;
  output logic [nis_pkg::NIRQ-1:0] irq_line;
  logic [nis_pkg::NIRQ-1:0] pls_r;
  // A pulse stands exactly one full clock, the shortest legal width
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pls_r <= '0;
    end else begin
      pls_r <= pls;
    end
  end
  assign irq_line = lvl | pls_r;
endmodule : nis_periph

/* File: tb/nis_ctrl_tb.sv */
// Self-checking bench for the nested interrupt state logic
`timescale 1ns/100ps
module nis_ctrl_tb;
  // ---------------------------------------------
  // Signals
  // ---------------------------------------------
  localparam logic [7:0] SP = nis_pkg::OFF_SETPEND0;
  localparam logic [7:0] CP = nis_pkg::OFF_CLRPEND0;
  localparam logic [7:0] AC = nis_pkg::OFF_ACTIVE0;
  localparam logic [7:0] ST = nis_pkg::OFF_STATUS;
  localparam logic [7:0] MK = nis_pkg::OFF_MASK;
  localparam logic [7:0] AR = nis_pkg::OFF_ARB;
  localparam logic [7:0] P0 = nis_pkg::OFF_PRI0;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [nis_pkg::NIRQ-1:0] irq_line;
  logic [nis_pkg::NIRQ-1:0] lvl = '0;
  logic [nis_pkg::NIRQ-1:0] pls = '0;
  logic nmi_line = 1'b0;
  logic nmi_ack = 1'b0;
  logic core_enter = 1'b0;
  logic core_exit = 1'b0;
  logic [5:0] enter_id = 6'h0;
  logic [5:0] exit_id = 6'h0;
  logic irq_req;
  logic nmi_req;
  logic irq_out;
  logic [5:0] irq_id;
  logic [2:0] irq_grp;
  logic [2:0] irq_sub;
  logic rd_ph = 1'b0;
  logic [31:0] exp_q[$];
  int err_total = 0;
  int samples_checked = 0;
  always #12.5 hclk = ~hclk;
  // ---------------------------------------------
  // Instances
  // ---------------------------------------------
  nis_ctrl i_nis_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .irq_line(irq_line),
    .nmi_line(nmi_line), .core_enter(core_enter),
    .core_enter_id(enter_id), .core_exit(core_exit),
    .core_exit_id(exit_id), .nmi_ack(nmi_ack), .irq_req(irq_req),
    .irq_id(irq_id), .irq_grp(irq_grp), .irq_sub(irq_sub),
    .nmi_req(nmi_req), .irq_out(irq_out));
  nis_periph i_nis_periph (.hclk(hclk), .hresetn(hresetn), .lvl(lvl),
    .pls(pls), .irq_line(irq_line));
  // ---------------------------------------------
  // Tasks
  // ---------------------------------------------
  task automatic conclude();
    // A read whose data never came back is a mismatch too
    if (exp_q.size() != 0)
      err_total++;
    $display("Compared %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  // Holds each phase until hready is sampled high, never assumes a count
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask : rd
  task automatic hs(input logic en, input logic [5:0] id);
    @(posedge hclk);
    core_enter <= en;
    core_exit <= !en;
    enter_id <= id;
    exit_id <= id;
    @(posedge hclk);
    core_enter <= 1'b0;
    core_exit <= 1'b0;
  endtask : hs
  task automatic pulse5();
    @(posedge hclk);
    pls <= 33'h20;
    @(posedge hclk);
    pls <= '0;
    cyc(4);
  endtask : pulse5
  // ---------------------------------------------
  // Read data monitor
  // ---------------------------------------------
  always @(posedge hclk) begin
    if (rd_ph && hreadyout === 1'b1 && exp_q.size() > 0) begin
      chk("hrdata", exp_q.pop_front(), hrdata);
      chk("hresp", 32'h0, {31'h0, hresp});
    end
    if (hreadyout === 1'b1)
      rd_ph <= hsel && htrans[1] && !hwrite;
  end
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    logic [31:0] d;
    void'($urandom(12672));
    cyc(10);
    hresetn <= 1'b1;
    rd(SP, 32'h0);
    rd(AC, 32'h0);
    rd(8'h3c, 32'h0);
    chk("irq_req", 32'h0, {31'h0, irq_req});
    wr(nis_pkg::OFF_ENABLE0, 32'hffffffff);
    wr(nis_pkg::OFF_ENABLE1, 32'h1);
    for (int w = 0; w < 9; w++) begin
      d = $urandom() & 32'h07070707;
      wr(P0 + 8'(4 * w), d);
      rd(P0 + 8'(4 * w), (w == 8) ? (d & 32'h7) : d);
    end
    wr(P0 + 8'h4, 32'h05000000);
    wr(P0 + 8'h8, 32'h00000300);
    wr(SP, 32'h280);
    cyc(2);
    rd(AR, 32'h80000309);
    chk("irq_id", 32'd9, {26'h0, irq_id});
    chk("irq_grp", 32'd3, {29'h0, irq_grp});
    wr(nis_pkg::OFF_PRIGRP, 32'h1);
    cyc(2);
    chk("irq_grp", 32'd1, {29'h0, irq_grp});
    chk("irq_sub", 32'd1, {29'h0, irq_sub});
    wr(P0 + 8'h8, 32'h00000700);
    cyc(2);
    rd(AR, 32'h80000507);
    wr(CP, 32'h280);
    wr(nis_pkg::OFF_SOFTWARE_IRQ_TRIGGER, 32'h4);
    rd(SP, 32'h10);
    wr(CP, 32'h10);
    rd(SP, 32'h0);
    lvl <= 33'h8;
    cyc(5);
    rd(SP, 32'h8);
    wr(CP, 32'h8);
    rd(SP, 32'h8);
    hs(1'b1, 6'd3);
    rd(SP, 32'h0);
    rd(AC, 32'h8);
    hs(1'b0, 6'd3);
    rd(SP, 32'h8);
    rd(AC, 32'h0);
    lvl <= '0;
    cyc(4);
    wr(CP, 32'h8);
    rd(SP, 32'h0);
    wr(nis_pkg::OFF_PULSE0, 32'h20);
    pulse5();
    rd(SP, 32'h20);
    hs(1'b1, 6'd5);
    pulse5();
    rd(SP, 32'h20);
    rd(AC, 32'h20);
    wr(CP, 32'h20);
    rd(AC, 32'h20);
    rd(SP, 32'h0);
    pulse5();
    hs(1'b0, 6'd5);
    rd(SP, 32'h20);
    wr(CP, 32'h20);
    rd(SP, 32'h0);
    pulse5();
    hs(1'b1, 6'd5);
    hs(1'b0, 6'd5);
    rd(SP, 32'h0);
    rd(AC, 32'h0);
    rd(ST, 32'h2);
    chk("irq_out", 32'h0, {31'h0, irq_out});
    wr(ST, 32'h3);
    wr(MK, 32'h3);
    nmi_line <= 1'b1;
    cyc(4);
    chk("nmi_req", 32'h1, {31'h0, nmi_req});
    chk("irq_out", 32'h1, {31'h0, irq_out});
    rd(ST, 32'h1);
    wr(MK, 32'h2);
    cyc(2);
    chk("irq_out", 32'h0, {31'h0, irq_out});
    wr(ST, 32'h1);
    rd(ST, 32'h0);
    nmi_ack <= 1'b1;
    nmi_line <= 1'b0;
    cyc(1);
    nmi_ack <= 1'b0;
    cyc(2);
    chk("nmi_req", 32'h0, {31'h0, nmi_req});
    conclude();
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    cyc(5000);
    err_total++;
    conclude();
  end
endmodule : nis_ctrl_tb
